/* bench/adc_cfg_monitor.sv */
`timescale 1ns/1ns
// --------------------------------
// Port-level checks on the bank
// --------------------------------
module adc_cfg_monitor (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        spiSelectN,
    input wire logic        spiDataOutEnN,
    input wire logic        timestampInputEnable,
    input wire logic        timestampEvent,
    input wire logic        refOutputEnable,
    input wire logic        refClockOutputOn,
    input wire logic [15:0] fullScaleCode,
    input wire logic [7:0]  powerModeCode1,
    input wire logic        lowPowerSelect,
    input wire logic        highPerfSelect,
    input wire logic        powerModeReserved,
    input wire logic [5:0]  pllFeedbackDivN,
    input wire logic        pllFeedbackDivBad,
    input wire logic        oscillatorBiasTuned,
    input wire logic [6:0]  oscillatorBiasCode
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_reset_values: assert property ($fell(reset) |-> fullScaleCode == 16'ha000
        && powerModeCode1 == 8'h4b) else $error("reset values wrong");
    chk_low_decode: assert property ($stable(powerModeCode1)[*3]
        |-> lowPowerSelect == (powerModeCode1 == 8'h46)) else $error("low decode");
    chk_high_decode: assert property ($stable(powerModeCode1)[*3]
        |-> highPerfSelect == (powerModeCode1 == 8'h4b)) else $error("high decode");
    chk_reserved_decode: assert property ($stable(powerModeCode1)[*3] |->
        powerModeReserved == !(powerModeCode1 inside {8'h46, 8'h4b})) else $error("rsv decode");
    chk_stamp_ignored: assert property (!timestampInputEnable[*3]
        |-> !timestampEvent) else $error("event while disabled");
    chk_ref_gate: assert property (!refOutputEnable[*3]
        |-> !refClockOutputOn) else $error("ref output while disabled");
    chk_ndiv_bad: assert property ($stable(pllFeedbackDivN)[*3]
        |-> pllFeedbackDivBad == (pllFeedbackDivN == 6'h00)) else $error("N flag");
    chk_bias_tuned: assert property ($stable(oscillatorBiasCode)[*3]
        |-> oscillatorBiasTuned == (oscillatorBiasCode == 7'h4a)) else $error("bias flag");
    chk_select_idle: assert property (spiSelectN[*8]
        |-> spiDataOutEnN) else $error("driving while idle");
    cover property (lowPowerSelect);
    cover property (timestampEvent);
    cover property (pllFeedbackDivBad);
endmodule : adc_cfg_monitor

bind adc_clock_range_power_cfg_regs adc_cfg_monitor i_mon (.*);

/* bench/adc_clock_range_power_cfg_regs_tb_top.sv */
`timescale 1ns/1ns
module adc_clock_range_power_cfg_regs_tb_top;
    logic clk = 0, reset = 1, spiClk = 0, spiSelectN = 1, spiDataIn = 0;
    logic timestampInput = 0, pllEnable = 1;
    logic [15:0] fullScaleCode;
    logic [7:0]  powerModeCode1;
    logic [2:0]  pllPostDivRatio, pllPreDivRatio;
    logic [5:0]  pllFeedbackDivN;
    logic [6:0]  oscillatorBiasCode;
    logic spiDataOut, spiDataOutEnN, lowPowerSelect, highPerfSelect, powerModeReserved;
    logic timestampInputEnable, timestampPeclMode, timestampEvent, refOutputEnable;
    logic refClockOutputOn, pllFeedbackDivBad, oscillatorBiasTuned;
    int errorCnt = 0, compares = 0, evCnt = 0;
    logic [7:0] pc [3] = '{8'h46, 8'h4b, 8'h55};
    logic [2:0] pe [3] = '{3'b100, 3'b010, 3'b001};
    logic [2:0] pr [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    logic [2:0] vr [4] = '{3'h5, 3'h4, 3'h3, 3'h0};
    adc_clock_range_power_cfg_regs i_dut (.*);
    always #50 clk = ~clk;
    // Count timestamp pulses half a cycle after they are launched
    always @(negedge clk) begin
        if (timestampEvent === 1'b1) begin
            evCnt++;
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic print_verdict;
        if (errorCnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    // One 24-bit frame, slow clock phases of 6 cycles
    task automatic frame(input logic rw, input logic [14:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        logic [23:0] f;
        f = {rw, a, d};
        spiSelectN = 0;
        repeat (6) @(negedge clk);
        for (int i = 23; i >= 0; i--) begin
            spiDataIn = f[i];
            repeat (6) @(negedge clk);
            if (i < 8) q[i] = spiDataOut;
            spiClk = 1;
            repeat (6) @(negedge clk);
            spiClk = 0;
        end
        repeat (6) @(negedge clk);
        spiSelectN = 1;
        repeat (12) @(negedge clk);
    endtask : frame
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        frame(1'b0, a, d, q);
    endtask : wr
    task automatic rdc(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] q;
        frame(1'b1, a, 8'h00, q);
        check({8'h00, q}, {8'h00, e});
    endtask : rdc
    initial begin
        #5000000;
        errorCnt++;
        print_verdict();
    end
    initial begin
        repeat (3) @(negedge clk);
        reset = 0;
        // Let the synchronisers settle before the first frame
        repeat (2) @(negedge clk);
        check(fullScaleCode, 16'ha000);
        rdc(15'h0031, 8'ha0);
        rdc(15'h003e, 8'h20);
        rdc(15'h003f, 8'h4f);
        check({15'h0, refClockOutputOn}, 16'h1);
        // Calibration, link and the other power bytes sit outside this bank
        for (int k = 0; k < 3; k++) begin
            wr(15'h0037, pc[k]);
            check({13'h0, lowPowerSelect, highPerfSelect, powerModeReserved}, {13'h0, pe[k]});
            check({8'h0, powerModeCode1}, {8'h0, pc[k]});
        end
        rdc(15'h0037, 8'h55);
        // PLL reset sits outside this bank; reserved bits are written as zero
        for (int k = 0; k < 4; k++) begin
            wr(15'h003d, {4'h0, 2'(k), 2'(3 - k)});
            check({10'h0, pllPostDivRatio, pllPreDivRatio}, {10'h0, pr[k], vr[3 - k]});
        end
        wr(15'h003e, 8'h00);
        check({15'h0, pllFeedbackDivBad}, 16'h1);
        wr(15'h003e, 8'h3f);
        check({9'h0, pllFeedbackDivBad, pllFeedbackDivN}, {10'h0, 6'h3f});
        wr(15'h003f, 8'h4a);
        check({8'h0, oscillatorBiasTuned, oscillatorBiasCode}, 16'h00ca);
        wr(15'h0030, 8'h5c);
        wr(15'h0031, 8'h20);
        check(fullScaleCode, 16'h205c);
        wr(15'h0040, 8'h5a);
        rdc(15'h0040, 8'h00);
        for (int e = 0; e < 2; e++) begin
            wr(15'h003b, {6'h0, 1'(1 - e), 1'(e)});
            check({14'h0, timestampPeclMode, timestampInputEnable}, {14'h0, 1'(1 - e), 1'(e)});
            repeat (2) begin
                timestampInput = 1;
                repeat (10) @(negedge clk);
                timestampInput = 0;
                repeat (10) @(negedge clk);
            end
            check(16'(evCnt), 16'(2 * e));
        end
        // PLL off gates the reference output although its enable is set
        pllEnable = 0;
        repeat (8) @(negedge clk);
        check({14'h0, refOutputEnable, refClockOutputOn}, 16'h2);
        pllEnable = 1;
        repeat (8) @(negedge clk);
        check({14'h0, refOutputEnable, refClockOutputOn}, 16'h3);
        wr(15'h003c, 8'h00);
        check({14'h0, refOutputEnable, refClockOutputOn}, 16'h0);
        print_verdict();
    end
endmodule : adc_clock_range_power_cfg_regs_tb_top

/* design/adc_cfg_pkg.sv */
package adc_cfg_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [14:0] FULL_SCALE_LO_OFFSET = 15'h0030; // Low byte of full-scale code
    localparam logic [14:0] FULL_SCALE_HI_OFFSET = 15'h0031; // High byte of full-scale code
    localparam logic [14:0] POWER_MODE_1_OFFSET  = 15'h0037;
    localparam logic [14:0] TIMESTAMP_OFFSET     = 15'h003b;
    localparam logic [14:0] REF_OUTPUT_OFFSET    = 15'h003c;
    localparam logic [14:0] PLL_DIV_PV_OFFSET    = 15'h003d;
    localparam logic [14:0] PLL_DIV_N_OFFSET     = 15'h003e;
    localparam logic [14:0] OSCILLATOR_BIAS_CODE_OFFSET      = 15'h003f;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [15:0] FULL_SCALE_RESET = 16'ha000;
    localparam logic [7:0]  POWER_MODE_RESET = 8'h4b;
    localparam logic [7:0]  TIMESTAMP_RESET  = 8'h00;
    localparam logic [7:0]  REF_OUTPUT_RESET = 8'h01;
    localparam logic [7:0]  PLL_DIV_PV_RESET = 8'h00;
    localparam logic [7:0]  PLL_DIV_N_RESET  = 8'h20;
    localparam logic [7:0]  OSCILLATOR_BIAS_CODE_RESET   = 8'h4f;

    // ----------------------------------------
    // Field positions and codes
    // ----------------------------------------
    localparam int          TS_ENABLE_BIT     = 0;        // Timestamp receiver enable
    localparam int          TS_PECL_BIT       = 1;        // Timestamp PECL-style mode
    localparam int          REF_ENABLE_BIT    = 0;        // Reference output enable
    localparam int          P_DIV_LSB         = 2;        // P divider field 3:2
    localparam int          V_DIV_LSB         = 0;        // V divider field 1:0
    localparam int          N_DIV_MSB         = 5;        // N divider field 5:0
    localparam int          OSCILLATOR_BIAS_CODE_MSB      = 6;        // Bias field 6:0
    localparam logic [7:0]  POWER_CODE_LOW    = 8'h46;    // Low-power mode
    localparam logic [7:0]  POWER_CODE_HIGH   = 8'h4b;    // High-performance mode
    localparam logic [6:0]  OSCILLATOR_BIAS_CODE_TUNED    = 7'h4a;    // Preferred bias with PLL in use
    localparam logic [5:0]  N_DIV_ZERO        = 6'h00;    // Unsupported N ratio
    localparam logic [1:0]  DIV_CODE_0        = 2'h0;
    localparam logic [1:0]  DIV_CODE_1        = 2'h1;
    localparam logic [1:0]  DIV_CODE_2        = 2'h2;
    localparam logic [2:0]  P_RATIO_0         = 3'h1;     // Divide by 1
    localparam logic [2:0]  P_RATIO_1         = 3'h2;     // Divide by 2
    localparam logic [2:0]  P_RATIO_2         = 3'h4;     // Divide by 4
    localparam logic [2:0]  V_RATIO_0         = 3'h5;     // Divide by 5
    localparam logic [2:0]  V_RATIO_1         = 3'h4;     // Divide by 4
    localparam logic [2:0]  V_RATIO_2         = 3'h3;     // Divide by 3
    localparam logic [2:0]  RATIO_RESERVED    = 3'h0;     // Reserved code shows zero

    // ----------------------------------------
    // Serial port frame
    // ----------------------------------------
    localparam logic [4:0]  FRAME_LAST_BIT    = 5'h17;    // 24 bits: R/W, address, data
    localparam logic [4:0]  HEADER_LAST_BIT   = 5'h0f;    // 16 bits: R/W and address
    localparam logic [4:0]  DATA_FIRST_BIT    = 5'h10;    // First data bit index

    // ----------------------------------------
    // Serial port states
    // ----------------------------------------
    typedef enum logic [2:0] {
        SPI_IDLE  = 3'b001,
        SPI_SHIFT = 3'b010,
        SPI_DONE  = 3'b100
    } spi_state_t;

endpackage : adc_cfg_pkg

/* design/adc_clock_range_power_cfg_regs.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Configuration register bank behind the serial control port
// ----------------------------------------
module adc_clock_range_power_cfg_regs (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        spiClk,              // Serial clock pin, idle low
    input  wire logic        spiSelectN,          // Serial select pin, active low
    input  wire logic        spiDataIn,           // Serial data in pin
    output logic             spiDataOut,          // Serial read data
    output logic             spiDataOutEnN,       // Low while driving read data
    input  wire logic        timestampInput,      // Timestamp pin
    input  wire logic        pllEnable,           // PLL enable pin
    output logic [15:0]      fullScaleCode,
    output logic [7:0]       powerModeCode1,
    output logic             lowPowerSelect,
    output logic             highPerfSelect,
    output logic             powerModeReserved,
    output logic             timestampInputEnable,
    output logic             timestampPeclMode,
    output logic             timestampEvent,      // One-cycle pulse per accepted edge
    output logic             refOutputEnable,
    output logic             refClockOutputOn,
    output logic [2:0]       pllPostDivRatio,
    output logic [2:0]       pllPreDivRatio,
    output logic [5:0]       pllFeedbackDivN,
    output logic             pllFeedbackDivBad,
    output logic [6:0]       oscillatorBiasCode,
    output logic             oscillatorBiasTuned
);

    // ----------------------------------------
    // Synchronised pins
    // ----------------------------------------
    logic sclkLevel;        // Filtered serial clock
    logic selectLevelN;     // Filtered select
    logic sdiLevel;         // Filtered data in
    logic tsLevel;          // Filtered timestamp
    logic pllEnLevel;       // Filtered PLL enable

    pin_sync #(.RESET_LEVEL(1'b0)) syncSclk (
        .clk(clk), .reset(reset), .pinIn(spiClk), .level(sclkLevel)
    );
    pin_sync #(.RESET_LEVEL(1'b1)) syncSelect (
        .clk(clk), .reset(reset), .pinIn(spiSelectN), .level(selectLevelN)
    );
    pin_sync #(.RESET_LEVEL(1'b0)) syncSdi (
        .clk(clk), .reset(reset), .pinIn(spiDataIn), .level(sdiLevel)
    );
    pin_sync #(.RESET_LEVEL(1'b0)) syncTimestamp (
        .clk(clk), .reset(reset), .pinIn(timestampInput), .level(tsLevel)
    );
    pin_sync #(.RESET_LEVEL(1'b0)) syncPllEn (
        .clk(clk), .reset(reset), .pinIn(pllEnable), .level(pllEnLevel)
    );

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [15:0] fullScale_reg;     // Full-scale code
    logic [7:0]  powerMode_reg;     // First power-mode byte
    logic [7:0]  timestamp_reg;     // Timestamp control
    logic [7:0]  refOutput_reg;     // Reference output control
    logic [7:0]  divPv_reg;         // P and V divider codes
    logic [7:0]  divN_reg;          // N divider ratio
    logic [7:0]  vcoBias_reg;       // Oscillator bias

    // ----------------------------------------
    // Serial port state
    // ----------------------------------------
    adc_cfg_pkg::spi_state_t state_reg;
    adc_cfg_pkg::spi_state_t state_next;
    logic        sclkPrev_reg;      // Last filtered clock level
    logic [4:0]  bitCount_reg;      // Bits taken this frame
    logic [22:0] shift_reg;         // Incoming bits
    logic [7:0]  readShift_reg;     // Outgoing read byte
    logic        readFrame_reg;     // Current frame is a read
    logic        sdoDrive_reg;      // Read data being driven
    logic        sdo_reg;           // Read data bit
    logic        tsPrev_reg;        // Last filtered timestamp level
    logic        tsEvent_reg;       // Timestamp edge pulse

    logic        spiRise;           // Serial clock rising edge
    logic        spiFall;           // Serial clock falling edge
    logic        selected;          // Select held active
    logic [23:0] frameWord;         // Full frame including current bit
    logic [15:0] headerWord;        // R/W and address including current bit
    logic        writeStrobe;       // Frame completes a write
    logic        headerDone;        // Address complete this edge

    assign spiRise    = sclkLevel & ~sclkPrev_reg;
    assign spiFall    = ~sclkLevel & sclkPrev_reg;
    assign selected   = ~selectLevelN;
    assign frameWord  = {shift_reg, sdiLevel};
    assign headerWord = {shift_reg[14:0], sdiLevel};
    assign headerDone = (state_reg == adc_cfg_pkg::SPI_SHIFT) && selected && spiRise
                        && (bitCount_reg == adc_cfg_pkg::HEADER_LAST_BIT);
    assign writeStrobe = (state_reg == adc_cfg_pkg::SPI_SHIFT) && selected && spiRise
                        && (bitCount_reg == adc_cfg_pkg::FRAME_LAST_BIT)
                        && !frameWord[23];

    // ----------------------------------------
    // Read data selection
    // ----------------------------------------
    function automatic logic [7:0] readValue(input logic [14:0] addr);
        logic [7:0] value;
        value = 8'h00;                      // Unmapped reads as zero
        case (addr)
            adc_cfg_pkg::FULL_SCALE_LO_OFFSET: value = fullScale_reg[7:0];
            adc_cfg_pkg::FULL_SCALE_HI_OFFSET: value = fullScale_reg[15:8];
            adc_cfg_pkg::POWER_MODE_1_OFFSET:  value = powerMode_reg;
            adc_cfg_pkg::TIMESTAMP_OFFSET:     value = timestamp_reg;
            adc_cfg_pkg::REF_OUTPUT_OFFSET:    value = refOutput_reg;
            adc_cfg_pkg::PLL_DIV_PV_OFFSET:    value = divPv_reg;
            adc_cfg_pkg::PLL_DIV_N_OFFSET:     value = divN_reg;
            adc_cfg_pkg::OSCILLATOR_BIAS_CODE_OFFSET:      value = vcoBias_reg;
            default:                           value = 8'h00;
        endcase
        return value;
    endfunction : readValue

    // ----------------------------------------
    // Frame state machine
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            adc_cfg_pkg::SPI_IDLE: begin
                if (selected) begin
                    state_next = adc_cfg_pkg::SPI_SHIFT;
                end
            end
            adc_cfg_pkg::SPI_SHIFT: begin
                if (!selected) begin
                    state_next = adc_cfg_pkg::SPI_IDLE;
                end else if (spiRise && bitCount_reg == adc_cfg_pkg::FRAME_LAST_BIT) begin
                    state_next = adc_cfg_pkg::SPI_DONE;
                end
            end
            adc_cfg_pkg::SPI_DONE: begin
                // Extra clocks are ignored until select drops
                if (!selected) begin
                    state_next = adc_cfg_pkg::SPI_IDLE;
                end
            end
            default: begin
                state_next = adc_cfg_pkg::SPI_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= adc_cfg_pkg::SPI_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // Shift in and bit count
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            sclkPrev_reg <= 1'b0;
            bitCount_reg <= 5'h00;
            shift_reg    <= 23'h000000;
        end else begin
            sclkPrev_reg <= sclkLevel;
            if (state_reg != adc_cfg_pkg::SPI_SHIFT) begin
                // Fresh frame on each select
                bitCount_reg <= 5'h00;
                shift_reg    <= 23'h000000;
            end else if (spiRise) begin
                bitCount_reg <= bitCount_reg + 5'h01;
                shift_reg    <= frameWord[22:0];
            end
        end
    end

    // ----------------------------------------
    // Read data shift out
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            readFrame_reg <= 1'b0;
            readShift_reg <= 8'h00;
            sdoDrive_reg  <= 1'b0;
            sdo_reg       <= 1'b0;
        end else if (!selected) begin
            // Release the line as soon as select drops
            readFrame_reg <= 1'b0;
            sdoDrive_reg  <= 1'b0;
        end else if (headerDone) begin
            readFrame_reg <= headerWord[15];
            readShift_reg <= readValue(headerWord[14:0]);
        end else if (spiFall && readFrame_reg && bitCount_reg >= adc_cfg_pkg::DATA_FIRST_BIT
                     && state_reg == adc_cfg_pkg::SPI_SHIFT) begin
            // Present next bit ahead of the following rising edge
            sdoDrive_reg  <= 1'b1;
            sdo_reg       <= readShift_reg[7];
            readShift_reg <= {readShift_reg[6:0], 1'b0};
        end
    end

    assign spiDataOut    = sdo_reg;
    assign spiDataOutEnN = ~sdoDrive_reg;

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Full-scale code, one byte per address
    always_ff @(posedge clk) begin
        if (reset) begin
            fullScale_reg <= adc_cfg_pkg::FULL_SCALE_RESET;
        end else if (writeStrobe) begin
            if (frameWord[22:8] == adc_cfg_pkg::FULL_SCALE_LO_OFFSET) begin
                fullScale_reg[7:0] <= frameWord[7:0];
            end else if (frameWord[22:8] == adc_cfg_pkg::FULL_SCALE_HI_OFFSET) begin
                fullScale_reg[15:8] <= frameWord[7:0];
            end
        end
    end

    // Byte registers, stored whole including reserved bits
    always_ff @(posedge clk) begin
        if (reset) begin
            powerMode_reg <= adc_cfg_pkg::POWER_MODE_RESET;
            timestamp_reg <= adc_cfg_pkg::TIMESTAMP_RESET;
            refOutput_reg <= adc_cfg_pkg::REF_OUTPUT_RESET;
            divPv_reg     <= adc_cfg_pkg::PLL_DIV_PV_RESET;
            divN_reg      <= adc_cfg_pkg::PLL_DIV_N_RESET;
            vcoBias_reg   <= adc_cfg_pkg::OSCILLATOR_BIAS_CODE_RESET;
        end else if (writeStrobe) begin
            case (frameWord[22:8])
                adc_cfg_pkg::POWER_MODE_1_OFFSET: powerMode_reg <= frameWord[7:0];
                adc_cfg_pkg::TIMESTAMP_OFFSET:    timestamp_reg <= frameWord[7:0];
                adc_cfg_pkg::REF_OUTPUT_OFFSET:   refOutput_reg <= frameWord[7:0];
                adc_cfg_pkg::PLL_DIV_PV_OFFSET:   divPv_reg     <= frameWord[7:0];
                adc_cfg_pkg::PLL_DIV_N_OFFSET:    divN_reg      <= frameWord[7:0];
                adc_cfg_pkg::OSCILLATOR_BIAS_CODE_OFFSET:     vcoBias_reg   <= frameWord[7:0];
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end
    end

    // ----------------------------------------
    // Decoded controls
    // ----------------------------------------
    // Power mode and full-scale outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            fullScaleCode     <= adc_cfg_pkg::FULL_SCALE_RESET;
            powerModeCode1    <= adc_cfg_pkg::POWER_MODE_RESET;
            lowPowerSelect    <= 1'b0;
            highPerfSelect    <= 1'b1;
            powerModeReserved <= 1'b0;
        end else begin
            fullScaleCode     <= fullScale_reg;
            powerModeCode1    <= powerMode_reg;
            lowPowerSelect    <= (powerMode_reg == adc_cfg_pkg::POWER_CODE_LOW);
            highPerfSelect    <= (powerMode_reg == adc_cfg_pkg::POWER_CODE_HIGH);
            powerModeReserved <= (powerMode_reg != adc_cfg_pkg::POWER_CODE_LOW)
                                 && (powerMode_reg != adc_cfg_pkg::POWER_CODE_HIGH);
        end
    end

    // Timestamp and reference output controls
    always_ff @(posedge clk) begin
        if (reset) begin
            timestampInputEnable <= 1'b0;
            timestampPeclMode    <= 1'b0;
            refOutputEnable      <= 1'b1;
            refClockOutputOn     <= 1'b0;
        end else begin
            timestampInputEnable <= timestamp_reg[adc_cfg_pkg::TS_ENABLE_BIT];
            timestampPeclMode    <= timestamp_reg[adc_cfg_pkg::TS_PECL_BIT];
            refOutputEnable      <= refOutput_reg[adc_cfg_pkg::REF_ENABLE_BIT];
            refClockOutputOn     <= refOutput_reg[adc_cfg_pkg::REF_ENABLE_BIT]
                                    & pllEnLevel;
        end
    end

    // Timestamp edges are taken only while the receiver is enabled
    always_ff @(posedge clk) begin
        if (reset) begin
            tsPrev_reg  <= 1'b0;
            tsEvent_reg <= 1'b0;
        end else begin
            tsPrev_reg  <= tsLevel;
            tsEvent_reg <= tsLevel & ~tsPrev_reg
                           & timestamp_reg[adc_cfg_pkg::TS_ENABLE_BIT];
        end
    end

    assign timestampEvent = tsEvent_reg;

    // PLL divider ratios and bias
    always_ff @(posedge clk) begin
        if (reset) begin
            pllPostDivRatio     <= adc_cfg_pkg::P_RATIO_0;
            pllPreDivRatio      <= adc_cfg_pkg::V_RATIO_0;
            pllFeedbackDivN     <= adc_cfg_pkg::PLL_DIV_N_RESET[adc_cfg_pkg::N_DIV_MSB:0];
            pllFeedbackDivBad   <= 1'b0;
            oscillatorBiasCode  <= adc_cfg_pkg::OSCILLATOR_BIAS_CODE_RESET[adc_cfg_pkg::OSCILLATOR_BIAS_CODE_MSB:0];
            oscillatorBiasTuned <= 1'b0;
        end else begin
            case (divPv_reg[adc_cfg_pkg::P_DIV_LSB +: 2])
                adc_cfg_pkg::DIV_CODE_0: pllPostDivRatio <= adc_cfg_pkg::P_RATIO_0;
                adc_cfg_pkg::DIV_CODE_1: pllPostDivRatio <= adc_cfg_pkg::P_RATIO_1;
                adc_cfg_pkg::DIV_CODE_2: pllPostDivRatio <= adc_cfg_pkg::P_RATIO_2;
                default:                 pllPostDivRatio <= adc_cfg_pkg::RATIO_RESERVED;
            endcase
            case (divPv_reg[adc_cfg_pkg::V_DIV_LSB +: 2])
                adc_cfg_pkg::DIV_CODE_0: pllPreDivRatio <= adc_cfg_pkg::V_RATIO_0;
                adc_cfg_pkg::DIV_CODE_1: pllPreDivRatio <= adc_cfg_pkg::V_RATIO_1;
                adc_cfg_pkg::DIV_CODE_2: pllPreDivRatio <= adc_cfg_pkg::V_RATIO_2;
                default:                 pllPreDivRatio <= adc_cfg_pkg::RATIO_RESERVED;
            endcase
            pllFeedbackDivN     <= divN_reg[adc_cfg_pkg::N_DIV_MSB:0];
            pllFeedbackDivBad   <= (divN_reg[adc_cfg_pkg::N_DIV_MSB:0]
                                    == adc_cfg_pkg::N_DIV_ZERO);
            oscillatorBiasCode  <= vcoBias_reg[adc_cfg_pkg::OSCILLATOR_BIAS_CODE_MSB:0];
            oscillatorBiasTuned <= (vcoBias_reg[adc_cfg_pkg::OSCILLATOR_BIAS_CODE_MSB:0]
                                    == adc_cfg_pkg::OSCILLATOR_BIAS_CODE_TUNED);
        end
    end

endmodule : adc_clock_range_power_cfg_regs

/* design/pin_sync.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b0   // Level shown during reset
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pinIn,
    output logic      level
);

    logic stage1_reg;   // Metastability catcher, read only by stage2
    logic stage2_reg;
    logic stage3_reg;

    // Shift chain
    always_ff @(posedge clk) begin
        if (reset) begin
            stage1_reg <= RESET_LEVEL;
            stage2_reg <= RESET_LEVEL;
            stage3_reg <= RESET_LEVEL;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Output follows only once stages two and three agree
    always_ff @(posedge clk) begin
        if (reset) begin
            level <= RESET_LEVEL;
        end else if (stage2_reg == stage3_reg) begin
            level <= stage3_reg;
        end
    end

endmodule : pin_sync
